// ---- design/nvdpc_ctrl.sv ----
// Nonvolatile data page controller with control register and option byte.
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Overview of operation
// - Each 64-byte page appears at data addresses 00h to 3Fh via loads/stores.
// - Bank value 01h selects page 0, 02h selects page 1, 00h selects none.
// - With no page selected, accesses do nothing and contents stay unchanged.
// - Standby bit 6 disables the array; all array accesses become meaningless.
// - Busy bit 1 is set for the whole programming cycle, then cleared.
// - While busy, array accesses abort but the running program cycle finishes.
// - While busy, control writes are ignored; only busy reads back.
// - With standby, busy and parallel mode clear, reads return data with normal timing.
// - No write cycle starts unless program-enable bit 0 is set.
// - Byte mode stores program the addressed byte directly, no buffer.
// - Setting parallel mode clears the eight latch used flags; first store latches row.
// - A row is eight bytes sharing A7..A3; A2..A0 select the byte.
// - Parallel start programs only bytes written since parallel mode began.
// - Parallel start sets only with enable and parallel mode both set.
// - End of a parallel cycle clears parallel mode and parallel start.
// - Clearing parallel mode before start discards latches, array untouched.
// - The option byte is applied at every reset and is not software visible.
// - Option bit 3 high selects hardware watchdog activation at reset.
// - Option bit 5 high blocks external readout of program memory.
// - Unprogrammed locations read back as FFh.
// ************************************************************
module nvdpc_ctrl
    import nvdpc_pkg::*;
#(
    parameter int PROG_CYCLES = NVDPC_PROG_CYCLES
)(
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire nvdpc_req_t cpu_req,
    input  wire logic [7:0] option_byte,
    output logic [7:0]      cpu_rdata,
    output logic            cpu_rvalid,
    output logic            watchdog_hw_activation,
    output logic            readout_protect,
    output logic            array_standby
);

    if (PROG_CYCLES < 1 || PROG_CYCLES > 65535)
    begin : g_bad_cycles
        $error("PROG_CYCLES out of range");
    end

    // ************************************************************
    // State
    // ************************************************************
    // The array is 128 bytes; bit 6 of the index is the page.
    logic [7:0]   mem_r [0:127];
    logic         init_r;
    logic [6:0]   init_idx_r;
    logic [7:0]   bank_r, bank_nxt;
    logic         ena_r, ena_nxt;
    logic         stby_r, stby_nxt;
    logic         row_write_r, row_write_nxt;
    logic         pstart_r, pstart_nxt;
    logic         row_vld_r, row_vld_nxt;
    logic [3:0]   row_r, row_nxt;
    logic [7:0]   lat_data_r [0:7];
    logic [7:0]   lat_used_r, lat_used_nxt;
    nvdpc_state_t st_r, st_nxt;
    logic [15:0]  cnt_r, cnt_nxt;
    logic         bpend_r, bpend_nxt;
    logic [6:0]   baddr_r, baddr_nxt;
    logic [7:0]   bdata_r, bdata_nxt;
    logic [7:0]   rdata_nxt;
    logic         watchdog_hw_activation_r, prot_r;

    function automatic logic page_sel(input logic [7:0] b);
        page_sel = (b == NVDPC_BANK_PAGE0) || (b == NVDPC_BANK_PAGE1);
    endfunction

    logic       busy;
    logic       in_page;
    logic       arr_ok;
    logic [6:0] arr_idx;
    logic       ctl_wr;
    logic [2:0] lane;

    assign busy    = (st_r == NVDPC_PROG);
    assign in_page = cpu_req.addr <= NVDPC_PAGE_LAST;
    assign arr_ok  = in_page && page_sel(bank_r) && !stby_r && !busy;
    assign arr_idx = {bank_r[1], cpu_req.addr[5:0]};
    assign ctl_wr  = cpu_req.wr && cpu_req.addr == NVDPC_CTL_ADDR && !busy;
    assign lane    = cpu_req.addr[2:0];

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        bank_nxt     = bank_r;
        ena_nxt      = ena_r;
        stby_nxt     = stby_r;
        row_write_nxt    = row_write_r;
        pstart_nxt   = pstart_r;
        row_vld_nxt  = row_vld_r;
        row_nxt      = row_r;
        lat_used_nxt = lat_used_r;
        st_nxt       = st_r;
        cnt_nxt      = cnt_r;
        bpend_nxt    = 1'b0;
        baddr_nxt    = baddr_r;
        bdata_nxt    = bdata_r;
        rdata_nxt    = NVDPC_ERASED;
        if (cpu_req.wr && cpu_req.addr == NVDPC_BANK_ADDR)
            bank_nxt = cpu_req.wdata;
        if (cpu_req.rd && cpu_req.addr == NVDPC_CTL_ADDR)
            rdata_nxt = {6'h00, busy, 1'b0};
        else if (cpu_req.rd && arr_ok && !row_write_r)
            rdata_nxt = mem_r[arr_idx];
        if (ctl_wr)
        begin
            ena_nxt   = cpu_req.wdata[NVDPC_BIT_ENA];
            stby_nxt  = cpu_req.wdata[NVDPC_BIT_STBY];
            row_write_nxt = cpu_req.wdata[NVDPC_BIT_ROW_WRITE];
            if (cpu_req.wdata[NVDPC_BIT_ROW_WRITE] && !row_write_r)
            begin
                lat_used_nxt = 8'h00;
                row_vld_nxt  = 1'b0;
            end
            if (!cpu_req.wdata[NVDPC_BIT_ROW_WRITE])
            begin
                lat_used_nxt = 8'h00;
                row_vld_nxt  = 1'b0;
            end
            if (cpu_req.wdata[NVDPC_BIT_PSTART]
                && cpu_req.wdata[NVDPC_BIT_ENA]
                && cpu_req.wdata[NVDPC_BIT_ROW_WRITE] && row_write_r && ena_r)
            begin
                pstart_nxt = 1'b1;
                st_nxt     = NVDPC_PROG;
                cnt_nxt    = 16'(PROG_CYCLES - 1);
            end
        end
        else if (cpu_req.wr && arr_ok && ena_r)
        begin
            if (row_write_r)
            begin
                // The page bit joins the row so page 1 rows stay in page 1.
                if (!row_vld_r || row_r == arr_idx[6:3])
                begin
                    row_vld_nxt        = 1'b1;
                    row_nxt            = arr_idx[6:3];
                    lat_used_nxt[lane] = 1'b1;
                end
            end
            else
            begin
                bpend_nxt = 1'b1;
                baddr_nxt = arr_idx;
                bdata_nxt = cpu_req.wdata;
                st_nxt    = NVDPC_PROG;
                cnt_nxt   = 16'(PROG_CYCLES - 1);
            end
        end
        if (busy)
        begin
            if (cnt_r == 16'h0000)
            begin
                st_nxt       = NVDPC_IDLE;
                row_write_nxt    = 1'b0;
                pstart_nxt   = 1'b0;
                row_vld_nxt  = 1'b0;
                lat_used_nxt = 8'h00;
            end
            else
                cnt_nxt = cnt_r - 16'h0001;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            bank_r     <= NVDPC_BANK_RESET;
            ena_r      <= NVDPC_CTL_RESET[NVDPC_BIT_ENA];
            stby_r     <= NVDPC_CTL_RESET[NVDPC_BIT_STBY];
            row_write_r    <= NVDPC_CTL_RESET[NVDPC_BIT_ROW_WRITE];
            pstart_r   <= NVDPC_CTL_RESET[NVDPC_BIT_PSTART];
            row_vld_r  <= 1'b0;
            row_r      <= 4'h0;
            lat_used_r <= 8'h00;
            st_r       <= NVDPC_IDLE;
            cnt_r      <= 16'h0000;
            bpend_r    <= 1'b0;
            baddr_r    <= 7'h00;
            bdata_r    <= 8'h00;
            cpu_rdata  <= NVDPC_ERASED;
            cpu_rvalid <= 1'b0;
        end
        else
        begin
            bank_r     <= bank_nxt;
            ena_r      <= ena_nxt;
            stby_r     <= stby_nxt;
            row_write_r    <= row_write_nxt;
            pstart_r   <= pstart_nxt;
            row_vld_r  <= row_vld_nxt;
            row_r      <= row_nxt;
            lat_used_r <= lat_used_nxt;
            st_r       <= st_nxt;
            cnt_r      <= cnt_nxt;
            bpend_r    <= bpend_nxt;
            baddr_r    <= baddr_nxt;
            bdata_r    <= bdata_nxt;
            cpu_rdata  <= rdata_nxt;
            cpu_rvalid <= cpu_req.rd;
        end
    end

    // Row latches hold data only; their used flags decide what programs.
    always_ff @(posedge clk_sys)
    begin
        if (cpu_req.wr && arr_ok && ena_r && row_write_r
            && (!row_vld_r || row_r == arr_idx[6:3]))
            lat_data_r[lane] <= cpu_req.wdata;
    end

    // ************************************************************
    // Array and option byte
    // ************************************************************
    // The array is filled with the erased value after reset, standing in
    // for a virgin part; a real cell would keep its data.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            init_r     <= 1'b1;
            init_idx_r <= 7'h00;
        end
        else if (init_r)
        begin
            mem_r[init_idx_r] <= NVDPC_ERASED;
            init_idx_r        <= init_idx_r + 7'h01;
            if (init_idx_r == 7'h7f)
                init_r <= 1'b0;
        end
        else
        begin
            if (bpend_r)
                mem_r[baddr_r] <= bdata_r;
            if (busy && cnt_r == 16'h0000 && pstart_r)
                for (int i = 0; i < 8; i++)
                    if (lat_used_r[i])
                        mem_r[{row_r, 3'(i)}] <= lat_data_r[i];
        end
    end

    // Option levels are sampled by the clock while reset is held.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            watchdog_hw_activation_r <= option_byte[NVDPC_OPT_WATCHDOG_HW_ACTIVATION];
            prot_r  <= option_byte[NVDPC_OPT_PROTECT];
        end
    end

    assign watchdog_hw_activation = watchdog_hw_activation_r;
    assign readout_protect        = prot_r;
    assign array_standby          = stby_r;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_busy_len;
        @(posedge clk_sys) disable iff (srst)
        $rose(busy) |-> busy [*2];
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too short");

    property p_pstart_guard;
        @(posedge clk_sys) disable iff (srst)
        $rose(pstart_r) |-> $past(row_write_r) && $past(ena_r)
            && $past(cpu_req.wdata[NVDPC_BIT_ENA]);
    endproperty
    a_pstart_guard: assert property (p_pstart_guard) else $error("bad start");

    property p_end_clears;
        @(posedge clk_sys) disable iff (srst)
        $fell(busy) |-> !row_write_r && !pstart_r;
    endproperty
    a_end_clears: assert property (p_end_clears) else $error("mode kept");

    property p_ctl_locked;
        @(posedge clk_sys) disable iff (srst)
        busy && $past(busy) |-> $stable(ena_r) && $stable(stby_r);
    endproperty
    a_ctl_locked: assert property (p_ctl_locked) else $error("ctl changed");

    property p_no_ena;
        @(posedge clk_sys) disable iff (srst)
        !ena_r && !busy |=> !busy;
    endproperty
    a_no_ena: assert property (p_no_ena) else $error("write w/o enable");

    property p_stby_rd;
        @(posedge clk_sys) disable iff (srst)
        stby_r && cpu_req.rd && in_page |=> cpu_rdata == NVDPC_ERASED;
    endproperty
    a_stby_rd: assert property (p_stby_rd) else $error("standby read");

    property p_nosel;
        @(posedge clk_sys) disable iff (srst)
        !page_sel(bank_r) && cpu_req.wr && in_page |=> !bpend_r;
    endproperty
    a_nosel: assert property (p_nosel) else $error("write no page");

    property p_rd_time;
        @(posedge clk_sys) disable iff (srst)
        cpu_req.rd |=> cpu_rvalid;
    endproperty
    a_rd_time: assert property (p_rd_time) else $error("read late");

endmodule
`default_nettype wire

// ---- design/nvdpc_pkg.sv ----
// Package of constants and types for the nonvolatile data page controller.
package nvdpc_pkg;

    // ************************************************************
    // Data space map
    // ************************************************************
    localparam logic [7:0] NVDPC_CTL_ADDR    = 8'hdf;
    localparam logic [7:0] NVDPC_BANK_ADDR   = 8'hcb;
    localparam logic [7:0] NVDPC_PAGE_LAST   = 8'h3f;
    localparam logic [7:0] NVDPC_BANK_PAGE0  = 8'h01;
    localparam logic [7:0] NVDPC_BANK_PAGE1  = 8'h02;

    // ************************************************************
    // Control register fields and reset values
    // ************************************************************
    localparam int         NVDPC_BIT_ENA     = 0;
    localparam int         NVDPC_BIT_BUSY    = 1;
    localparam int         NVDPC_BIT_ROW_WRITE   = 2;
    localparam int         NVDPC_BIT_PSTART  = 3;
    localparam int         NVDPC_BIT_STBY    = 6;
    localparam logic [7:0] NVDPC_CTL_RESET   = 8'h00;
    localparam logic [7:0] NVDPC_BANK_RESET  = 8'h00;
    localparam logic [7:0] NVDPC_ERASED      = 8'hff;

    // ************************************************************
    // Option byte fields and timing
    // ************************************************************
    localparam int         NVDPC_OPT_WATCHDOG_HW_ACTIVATION   = 3;
    localparam int         NVDPC_OPT_PROTECT = 5;
    localparam int         NVDPC_PROG_CYCLES = 64;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nvdpc_req_t;

    typedef enum logic [1:0] {
        NVDPC_IDLE,
        NVDPC_PROG
    } nvdpc_state_t;

endpackage

// ---- sim/nvdpc_cpu_model.sv ----
// CPU core model that issues data-space loads and stores to the controller.
`timescale 1ns/1ps
`default_nettype none
module nvdpc_cpu_model
    import nvdpc_pkg::*;
(
    input  wire logic       clk_sys,
    output var  nvdpc_req_t cpu_req,
    input  wire logic [7:0] cpu_rdata,
    input  wire logic       cpu_rvalid
);
    // ************************************************************
    // Bus cycles
    // ************************************************************
    // Control bits are write only, so the model keeps its own image.
    logic [7:0] ctl_image;

    initial
    begin
        cpu_req   = '0;
        ctl_image = 8'h00;
    end

    // Released address and data lines show the inverse of the last value.
    task automatic release_bus();
        cpu_req.rd    = 1'b0;
        cpu_req.wr    = 1'b0;
        cpu_req.addr  = ~cpu_req.addr;
        cpu_req.wdata = ~cpu_req.wdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == NVDPC_CTL_ADDR)
        begin
            v         = d & 8'hcf;
            ctl_image = v;
        end
        @(negedge clk_sys);
        cpu_req.wr    = 1'b1;
        cpu_req.addr  = a;
        cpu_req.wdata = v;
        @(posedge clk_sys);
        @(negedge clk_sys);
        release_bus();
    endtask

    // The answer is awaited for a few cycles only; a late one reads as X.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        n = 0;
        d = 8'hxx;
        @(negedge clk_sys);
        cpu_req.rd   = 1'b1;
        cpu_req.addr = a;
        @(posedge clk_sys);
        @(negedge clk_sys);
        release_bus();
        while (cpu_rvalid !== 1'b1 && n < 3)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (cpu_rvalid === 1'b1)
            d = cpu_rdata;
    endtask
endmodule
`default_nettype wire

// ---- sim/nvdpc_ctrl_tb_top.sv ----
// Self-checking testbench for the nonvolatile data page controller.
`timescale 1ns/1ps
`default_nettype none
module nvdpc_ctrl_tb_top
    import nvdpc_pkg::*;
    ;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    // A short programming time keeps the run brief but outlasts a poll.
    localparam int     PC = 16;
    localparam logic [7:0] CTL = NVDPC_CTL_ADDR;
    logic              clk_sys;
    logic              srst;
    logic [7:0]        option_byte;
    nvdpc_req_t        cpu_req;
    logic [7:0]        cpu_rdata;
    logic              cpu_rvalid;
    logic              wd_act;
    logic              rd_prot;
    logic              stby;
    logic [7:0]        d;
    logic [7:0]        ra [5];
    logic [7:0]        rx [5];
    int                errors;
    int                n_compared;

    nvdpc_ctrl #(.PROG_CYCLES(PC)) nvdpc_ctrl_inst (
        .clk_sys                (clk_sys),
        .srst                   (srst),
        .cpu_req                (cpu_req),
        .option_byte            (option_byte),
        .cpu_rdata              (cpu_rdata),
        .cpu_rvalid             (cpu_rvalid),
        .watchdog_hw_activation (wd_act),
        .readout_protect        (rd_prot),
        .array_standby          (stby)
    );

    nvdpc_cpu_model nvdpc_cpu_model_inst (
        .clk_sys    (clk_sys),
        .cpu_req    (cpu_req),
        .cpu_rdata  (cpu_rdata),
        .cpu_rvalid (cpu_rvalid)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic check(input string w, input logic [7:0] s,
                         input logic [7:0] e);
        n_compared++;
        if (s !== e)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", w, e, s);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        nvdpc_cpu_model_inst.wr(a, v);
    endtask

    task automatic rd_chk(input string w, input logic [7:0] a,
                          input logic [7:0] e);
        nvdpc_cpu_model_inst.rd(a, d);
        check(w, d, e);
    endtask

    task automatic wait_idle();
        int i;
        i = 0;
        do
        begin
            nvdpc_cpu_model_inst.rd(CTL, d);
            i++;
        end
        while (d !== 8'h00 && i < 200);
        check("busy end", d, 8'h00);
    endtask

    initial
    begin
        #(8 * 6000);
        errors++;
        $display("watchdog expired");
        conclude();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial
    begin
        errors      = 0;
        n_compared  = 0;
        srst        = 1'b1;
        option_byte = 8'h28;
        ra = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h20};
        rx = '{8'h11, 8'hff, 8'h22, 8'h33, 8'hff};
        repeat (20) @(negedge clk_sys);
        srst = 1'b0;
        repeat (130) @(negedge clk_sys);
        check("wdog", {7'h00, wd_act}, 8'h01);
        check("prot", {7'h00, rd_prot}, 8'h01);
        rd_chk("no page", 8'h05, NVDPC_ERASED);
        wr(CTL, 8'h01);
        wr(8'h05, 8'h3c);
        rd_chk("no page busy", CTL, 8'h00);
        wr(NVDPC_BANK_ADDR, NVDPC_BANK_PAGE0);
        rd_chk("virgin", 8'h05, NVDPC_ERASED);
        $display("test paging done");
        wr(8'h05, 8'haa);
        rd_chk("busy set", CTL, 8'h02);
        rd_chk("busy rd", 8'h05, NVDPC_ERASED);
        wr(CTL, 8'h40);
        wait_idle();
        check("ctl locked", {7'h00, stby}, 8'h00);
        rd_chk("byte", 8'h05, 8'haa);
        wr(8'h3f, 8'h5a);
        wait_idle();
        rd_chk("top", 8'h3f, 8'h5a);
        wr(NVDPC_BANK_ADDR, NVDPC_BANK_PAGE1);
        rd_chk("page1", 8'h05, NVDPC_ERASED);
        wr(NVDPC_BANK_ADDR, NVDPC_BANK_PAGE0);
        $display("test byte write done");
        wr(CTL, 8'h00);
        wr(8'h06, 8'h55);
        rd_chk("no ena busy", CTL, 8'h00);
        rd_chk("no ena", 8'h06, NVDPC_ERASED);
        wr(CTL, 8'h40);
        check("stby", {7'h00, stby}, 8'h01);
        rd_chk("stby rd", 8'h05, NVDPC_ERASED);
        wr(CTL, 8'h00);
        rd_chk("awake", 8'h05, 8'haa);
        $display("test enable and standby done");
        wr(CTL, 8'h01);
        wr(CTL, 8'h05);
        wr(8'h18, 8'h11);
        wr(8'h1a, 8'h22);
        wr(8'h1b, 8'h33);
        wr(CTL, 8'h0d);
        rd_chk("par busy", CTL, 8'h02);
        wait_idle();
        for (int i = 0; i < 5; i++)
            rd_chk("row", ra[i], rx[i]);
        wr(CTL, 8'h09);
        rd_chk("start no mode", CTL, 8'h00);
        wr(CTL, 8'h04);
        wr(CTL, 8'h0c);
        rd_chk("start no ena", CTL, 8'h00);
        $display("test parallel done");
        wr(CTL, 8'h01);
        wr(CTL, 8'h05);
        wr(8'h28, 8'h99);
        wr(CTL, 8'h01);
        rd_chk("abort busy", CTL, 8'h00);
        rd_chk("abort", 8'h28, NVDPC_ERASED);
        wr(8'h29, 8'h66);
        wait_idle();
        rd_chk("released", 8'h29, 8'h66);
        rd_chk("latch gone", 8'h28, NVDPC_ERASED);
        $display("test abort done");
        wr(CTL, 8'h40);
        option_byte = 8'h00;
        repeat (4) @(negedge clk_sys);
        check("opt held", {7'h00, wd_act}, 8'h01);
        srst = 1'b1;
        repeat (2) @(negedge clk_sys);
        check("opt wdog", {7'h00, wd_act}, 8'h00);
        check("opt prot", {7'h00, rd_prot}, 8'h00);
        check("rst stby", {7'h00, stby}, 8'h00);
        srst = 1'b0;
        $display("test option byte done");
        conclude();
    end
endmodule
`default_nettype wire
